/* inc/mseg_pkg.sv */
// package of constants and types for the multistage envelope generator
// Functional notes
// - six stages: two attacks, decays, releases
// - gate rise walks attack/decay stages at targets
// - no repeat: hold second decay level
// - gate fall jumps to first release immediately
// - factory mode uses built-in stage set
// - repeat loops attack/decay while gated
// - attack times set rise duration
// - release times set fall duration, slower larger
// - cutoff offset by contour times signed amount
package mseg_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_AMOUNT = 8'h04;
  localparam logic [7:0] ADDR_BASE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CUTOFF = 8'h10;
  localparam logic [7:0] ADDR_STAGE0 = 8'h20;
  localparam logic [7:0] ADDR_STAGE5 = 8'h34;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_REPEAT_BIT = 2;
  localparam int CTRL_ROUTE_BIT  = 3;
  localparam int STG_TIME_LSB    = 0;
  localparam int STG_LEVEL_LSB   = 8;
  localparam int STAT_STAGE_LSB  = 0;
  localparam int STAT_LEVEL_LSB  = 8;
  localparam int STAT_GATE_BIT   = 16;

  localparam logic [1:0] MODE_FACTORY = 2'h0;
  localparam logic [1:0] MODE_TIME    = 2'h1;
  localparam logic [1:0] MODE_TEMPO   = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0]  CTRL_RST   = 4'h1;
  localparam logic [7:0]  AMOUNT_RST = 8'h00;
  localparam logic [7:0]  BASE_RST   = 8'hFF;
  localparam logic [15:0] STAGE_RST  = 16'h0000;

  // built-in stage set, stage 0 in low bits, {level,time}
  localparam logic [95:0] FACTORY_SET = {
    16'h0030, 16'h3320, 16'h8010, 16'hD808, 16'hFF04, 16'hA602
  };

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ     = 125000000;
  localparam int SAMPLE_HZ  = 48000;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;

  // ----------------------------------------
  // stage states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ATK1 = 3'b001,
    ST_ATK2 = 3'b010,
    ST_DEC1 = 3'b011,
    ST_DEC2 = 3'b100,
    ST_REL1 = 3'b101,
    ST_REL2 = 3'b110
  } mseg_state_type;

endpackage

/* verif/mseg_top_sva.sv */
// assertion checker for the envelope generator ports
`timescale 1ns/1ns
module mseg_top_sva #(
  parameter int SAMPLE_DIV = 4
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        key_gate,
  input wire logic        voice_rst,
  input wire logic [7:0]  contour_level,
  input wire logic [2:0]  contour_stage,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // cycles since the last level change
  // ----------------------------------------
  int since_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) since_r <= 9999;
    else if (voice_rst) since_r <= 9999;
    else if ($changed(contour_level)) since_r <= 0;
    else if (since_r < 9999) since_r <= since_r + 1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_idle: assert property (
    voice_rst |=> contour_level == 8'h00 ##1 contour_stage == 3'h0)
    else $error("voice reset did not idle");
  a_level_step: assert property (
    $changed(contour_level) && !$past(voice_rst) |->
      contour_level == $past(contour_level) + 8'h01 ||
      contour_level == $past(contour_level) - 8'h01)
    else $error("level moved by more than one");
  a_level_rate: assert property (
    $changed(contour_level) |-> since_r >= SAMPLE_DIV - 1)
    else $error("level changed faster than the tick");
  a_stage_order: assert property (
    $changed(contour_stage) && !$past(voice_rst, 2) |->
      contour_stage == $past(contour_stage) + 3'h1 ||
      contour_stage == 3'h1 || contour_stage == 3'h5 ||
      (contour_stage == 3'h0 && $past(contour_stage) == 3'h6))
    else $error("illegal stage step");
  a_attack_start: assert property (
    $rose(key_gate) && !voice_rst |-> ##[1:3] contour_stage == 3'h1)
    else $error("gate rise did not start attack");
  a_release_jump: assert property (
    $fell(key_gate) && !voice_rst && contour_stage inside {[1:4]}
      |-> ##[1:3] contour_stage == 3'h5)
    else $error("gate fall did not enter release");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  c_hold: cover property (contour_stage == 3'h4);
  c_rel2: cover property (contour_stage == 3'h6);
  c_loop: cover property ($past(contour_stage) == 3'h4 &&
    contour_stage == 3'h1);
  c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind mseg_top mseg_top_sva #(.SAMPLE_DIV(SAMPLE_DIV)) i_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .key_gate(key_gate),
  .voice_rst(voice_rst), .contour_level(contour_level),
  .contour_stage(contour_stage), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* verif/mseg_voice_model.sv */
// voice control model driving note gate and voice reset
`timescale 1ns/1ns
module mseg_voice_model (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic gate_cmd,
  input  wire logic kill_cmd,
  output logic      key_gate,
  output logic      voice_rst
);
  // ----------------------------------------
  // registered gate and reset, same clock
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_gate  <= 1'b0;
      voice_rst <= 1'b0;
    end else begin
      key_gate  <= gate_cmd;
      voice_rst <= kill_cmd;
    end
  end
endmodule

/* verif/tb.sv */
// self-checking testbench for the envelope generator
`timescale 1ns/1ns
module tb;
  localparam int DIV = 4;
  logic        ref_clk, sys_rst, gate_cmd, kill_cmd, key_gate, voice_rst;
  logic [7:0]  contour_level, cutoff_destination, s_axi_awaddr;
  logic [7:0]  s_axi_araddr, r8, amt, base;
  logic [2:0]  contour_stage;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [15:0] lfsr_r;
  logic [7:0]  lvl [6];
  logic [7:0]  tim [6];
  int          bad_count, checks, cyc, t0, d1, d2;

  mseg_voice_model i_voice (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .gate_cmd(gate_cmd), .kill_cmd(kill_cmd), .key_gate(key_gate),
    .voice_rst(voice_rst));
  mseg_top #(.SAMPLE_DIV(DIV)) i_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .key_gate(key_gate), .voice_rst(voice_rst),
    .contour_level(contour_level), .cutoff_destination(cutoff_destination),
    .contour_stage(contour_stage), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ----------------------------------------
  // clock, cycle count, watchdog
  // ----------------------------------------
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  initial begin
    #480000;
    bad_count++;
    finish_test();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_dur(input int got, input int steps, input int t);
    int exp;
    exp = steps * (t + 1) * DIV;
    checks++;
    if (got < exp - 2 * (t + 2) * DIV || got > exp + 2 * (t + 2) * DIV) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_cut(logic [7:0] b, logic [7:0] a,
                                         logic [7:0] l);
    int v;
    v = int'(b) + ((int'($signed(a)) * int'(l)) >>> 7);
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
  endfunction
  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wait_sig(input logic [7:0] v, input bit on_lvl);
    int n;
    n = 0;
    while ((on_lvl ? contour_level : {5'h0, contour_stage}) !== v &&
           n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    chk32({31'h0, n < 20000}, 32'h1);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw, w;
    r8 = rnd();
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    tick(r8[1:0]);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    r8 = rnd();
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    tick(r8[1:0]);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {ref_clk, gate_cmd, kill_cmd, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {bad_count, checks, cyc} = '0;
    lfsr_r = 16'h5F47;
    sys_rst = 1'b1;
    tick(10);
    sys_rst <= 1'b0;
    tick(1);
    axi_rd(mseg_pkg::ADDR_CTRL, rd, rsp);
    chk32(rd, {28'h0, mseg_pkg::CTRL_RST});
    axi_rd(mseg_pkg::ADDR_BASE, rd, rsp);
    chk32(rd, {24'h0, mseg_pkg::BASE_RST});
    axi_rd(8'h3C, rd, rsp);
    chk32({rd[29:0], rsp}, {30'h0, mseg_pkg::RESP_SLVERR});
    axi_wr(mseg_pkg::ADDR_STATUS, 32'h1, rsp);
    chk32({30'h0, rsp}, {30'h0, mseg_pkg::RESP_SLVERR});
    r8 = rnd();
    lvl = '{{2'b01, r8[5:0]}, {2'b01, r8[5:0]} + 8'h20, {2'b01, r8[5:0]},
           8'h30, 8'h18, 8'h08};
    for (int i = 0; i < 6; i++) begin
      axi_rd(mseg_pkg::ADDR_STAGE0 + 8'(i * 4), rd, rsp);
      chk32(rd, {16'h0, mseg_pkg::STAGE_RST});
      r8 = rnd();
      tim[i] = (i > 3) ? 8'(2 * (i - 4)) : {6'h0, r8[1:0]};
      axi_wr(mseg_pkg::ADDR_STAGE0 + 8'(i * 4), {16'h0, lvl[i], tim[i]}, rsp);
    end
    gate_cmd <= 1'b1;
    t0 = cyc;
    wait_sig(8'h2, 0);
    chk_dur(cyc - t0, lvl[0], tim[0]);
    for (int s = 0; s < 3; s++) begin
      chk32({24'h0, contour_level}, {24'h0, lvl[s]});
      wait_sig(8'((s < 2) ? s + 3 : 4), 0);
    end
    wait_sig(lvl[3], 1);
    tick(100);
    axi_rd(mseg_pkg::ADDR_STATUS, rd, rsp);
    chk32(rd, {15'h0, 1'b1, lvl[3], 5'h0, 3'h4});
    for (int i = 0; i < 3; i++) begin
      amt = rnd();
      base = rnd();
      amt = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : amt;
      axi_wr(mseg_pkg::ADDR_AMOUNT, {24'h0, amt}, rsp);
      axi_wr(mseg_pkg::ADDR_BASE, {24'h0, base}, rsp);
      axi_wr(mseg_pkg::ADDR_CTRL, 32'h9, rsp);
      axi_rd(mseg_pkg::ADDR_CUTOFF, rd, rsp);
      chk32(rd, {24'h0, exp_cut(base, amt, lvl[3])});
      chk32({24'h0, cutoff_destination}, rd);
    end
    axi_wr(mseg_pkg::ADDR_CTRL, 32'h1, rsp);
    tick(4);
    chk32({24'h0, cutoff_destination}, {24'h0, base});
    gate_cmd <= 1'b0;
    t0 = cyc;
    tick(4);
    chk32({29'h0, contour_stage}, 32'h5);
    wait_sig(8'h6, 0);
    d1 = cyc - t0;
    t0 = cyc;
    wait_sig(8'h0, 0);
    d2 = cyc - t0;
    chk_dur(d1, 24, 0);
    chk_dur(d2, 16, 2);
    chk32({24'h0, contour_level}, {24'h0, lvl[5]});
    gate_cmd <= 1'b1;
    wait_sig(8'h1, 0);
    tick(20);
    r8 = contour_level;
    gate_cmd <= 1'b0;
    tick(4);
    r8 = contour_level + 8'h1 - r8;
    chk32({28'h0, r8 <= 8'h2, contour_stage}, 32'hD);
    wait_sig(8'h0, 0);
    axi_wr(mseg_pkg::ADDR_CTRL, 32'h5, rsp);
    gate_cmd <= 1'b1;
    wait_sig(8'h4, 0);
    wait_sig(8'h1, 0);
    for (int m = 0; m < 4; m++) begin
      gate_cmd <= 1'b0;
      kill_cmd <= 1'b1;
      tick(1);
      kill_cmd <= 1'b0;
      tick(3);
      chk32({21'h0, contour_level, contour_stage}, 32'h0);
      axi_wr(mseg_pkg::ADDR_CTRL, 32'(m), rsp);
      tick(8);
      gate_cmd <= 1'b1;
      wait_sig(8'h2, 0);
      r8 = (m == 0) ? mseg_pkg::FACTORY_SET[15:8] : lvl[0];
      chk32({24'h0, contour_level}, {24'h0, r8});
    end
    finish_test();
  end
endmodule

/* verilog/mseg_stage_sel.sv */
// selects the time and level of the active stage
`timescale 1ns/1ns
module mseg_stage_sel (
  input  wire logic [1:0]  mode,
  input  wire logic [2:0]  stage_idx,
  input  wire logic [95:0] prog_set,
  output logic      [7:0]  stage_time,
  output logic      [7:0]  stage_level
);

  logic [15:0] word;

  function automatic logic [15:0] pick(input logic [95:0] set,
                                       input logic [2:0]  idx);
    pick = set[idx*16 +: 16];
  endfunction

  // ----------------------------------------
  // source select
  // ----------------------------------------
  always_comb begin
    if (mode == mseg_pkg::MODE_FACTORY) begin
      word = pick(mseg_pkg::FACTORY_SET, stage_idx);
    end else begin
      word = pick(prog_set, stage_idx);
    end
    stage_time  = word[mseg_pkg::STG_TIME_LSB +: 8];
    stage_level = word[mseg_pkg::STG_LEVEL_LSB +: 8];
  end

endmodule

/* verilog/mseg_tick_div.sv */
// sample tick divider for the envelope generator
`timescale 1ns/1ns
module mseg_tick_div #(
  parameter int DIV = mseg_pkg::SAMPLE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  output logic      tick
);

  logic [15:0] cnt_r;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_r == 16'(DIV - 1)) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

/* verilog/mseg_top.sv */
// envelope generator with cutoff routing and axi4-lite registers
`timescale 1ns/1ns
module mseg_top #(
  parameter int SAMPLE_DIV = mseg_pkg::SAMPLE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        key_gate,
  input  wire logic        voice_rst,
  output logic      [7:0]  contour_level,
  output logic      [7:0]  cutoff_destination,
  output logic      [2:0]  contour_stage,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0]            ctrl_r;
  logic [7:0]            amount_r;
  logic [7:0]            base_r;
  logic [15:0]           stage_r [6];
  logic [95:0]           prog_set;
  logic [7:0]            aw_addr_r;
  logic                  aw_held_r;
  logic [31:0]           w_data_r;
  logic [3:0]            w_strb_r;
  logic                  w_held_r;
  logic                  wr_fire;
  logic                  wr_hit;
  logic [31:0]           rd_word;
  logic                  rd_hit;
  mseg_pkg::mseg_state_type state_r;
  logic [7:0]            presc_r;
  logic                  gate_r;
  logic                  tick;
  logic [2:0]            stage_idx;
  logic [7:0]            stage_time;
  logic [7:0]            stage_level;
  logic                  active;
  logic                  at_target;
  logic                  step_due;
  logic [7:0]            cutoff_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic stage_addr(input logic [7:0] a);
    stage_addr = (a >= mseg_pkg::ADDR_STAGE0) &&
                 (a <= mseg_pkg::ADDR_STAGE5) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] stage_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - mseg_pkg::ADDR_STAGE0;
    stage_of = d[4:2];
  endfunction

  function automatic logic [7:0] clamp8(input logic signed [17:0] v);
    if (v < 18'sd0) begin
      clamp8 = 8'h00;
    end else if (v > 18'sd255) begin
      clamp8 = 8'hFF;
    end else begin
      clamp8 = v[7:0];
    end
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit  = (aw_addr_r == mseg_pkg::ADDR_CTRL) ||
                   (aw_addr_r == mseg_pkg::ADDR_AMOUNT) ||
                   (aw_addr_r == mseg_pkg::ADDR_BASE) ||
                   stage_addr(aw_addr_r);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_r     <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_r     <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mseg_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? mseg_pkg::RESP_OKAY
                             : mseg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r   <= mseg_pkg::CTRL_RST;
      amount_r <= mseg_pkg::AMOUNT_RST;
      base_r   <= mseg_pkg::BASE_RST;
      for (int i = 0; i < 6; i++) begin
        stage_r[i] <= mseg_pkg::STAGE_RST;
      end
    end else if (wr_fire) begin
      if (aw_addr_r == mseg_pkg::ADDR_CTRL) begin
        ctrl_r <= 4'(merge({28'h0, ctrl_r}, w_data_r, w_strb_r));
      end
      if (aw_addr_r == mseg_pkg::ADDR_AMOUNT) begin
        amount_r <= 8'(merge({24'h0, amount_r}, w_data_r, w_strb_r));
      end
      if (aw_addr_r == mseg_pkg::ADDR_BASE) begin
        base_r <= 8'(merge({24'h0, base_r}, w_data_r, w_strb_r));
      end
      if (stage_addr(aw_addr_r)) begin
        stage_r[stage_of(aw_addr_r)] <= 16'(merge(
          {16'h0, stage_r[stage_of(aw_addr_r)]}, w_data_r, w_strb_r));
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == mseg_pkg::ADDR_CTRL) begin
      rd_word = {28'h0, ctrl_r};
    end else if (s_axi_araddr == mseg_pkg::ADDR_AMOUNT) begin
      rd_word = {24'h0, amount_r};
    end else if (s_axi_araddr == mseg_pkg::ADDR_BASE) begin
      rd_word = {24'h0, base_r};
    end else if (s_axi_araddr == mseg_pkg::ADDR_STATUS) begin
      rd_word[mseg_pkg::STAT_STAGE_LSB +: 3] = state_r;
      rd_word[mseg_pkg::STAT_LEVEL_LSB +: 8] = contour_level;
      rd_word[mseg_pkg::STAT_GATE_BIT]       = gate_r;
    end else if (s_axi_araddr == mseg_pkg::ADDR_CUTOFF) begin
      rd_word = {24'h0, cutoff_destination};
    end else if (stage_addr(s_axi_araddr)) begin
      rd_word = {16'h0, stage_r[stage_of(s_axi_araddr)]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mseg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? mseg_pkg::RESP_OKAY
                              : mseg_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= !s_axi_rready;
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // ----------------------------------------
  // stage parameters and tick
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      prog_set[i*16 +: 16] = stage_r[i];
    end
  end

  assign stage_idx = (state_r == mseg_pkg::ST_IDLE) ? 3'h0
                                                    : state_r - 3'h1;

  mseg_stage_sel u_sel (
    .mode        (ctrl_r[mseg_pkg::CTRL_MODE_LSB +: 2]),
    .stage_idx   (stage_idx),
    .prog_set    (prog_set),
    .stage_time  (stage_time),
    .stage_level (stage_level)
  );

  mseg_tick_div #(
    .DIV (SAMPLE_DIV)
  ) u_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // ----------------------------------------
  // contour sequencer
  // ----------------------------------------
  assign active    = state_r != mseg_pkg::ST_IDLE;
  assign at_target = contour_level == stage_level;
  assign step_due  = tick && (presc_r >= stage_time);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= key_gate;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= mseg_pkg::ST_IDLE;
    end else if (voice_rst) begin
      state_r <= mseg_pkg::ST_IDLE;
    end else if (key_gate && !gate_r) begin
      state_r <= mseg_pkg::ST_ATK1;
    end else if (!key_gate && gate_r && active &&
                 state_r != mseg_pkg::ST_REL2) begin
      state_r <= mseg_pkg::ST_REL1;
    end else if (tick && at_target) begin
      case (state_r)
        mseg_pkg::ST_ATK1: begin
          state_r <= mseg_pkg::ST_ATK2;
        end
        mseg_pkg::ST_ATK2: begin
          state_r <= mseg_pkg::ST_DEC1;
        end
        mseg_pkg::ST_DEC1: begin
          state_r <= mseg_pkg::ST_DEC2;
        end
        mseg_pkg::ST_DEC2: begin
          if (ctrl_r[mseg_pkg::CTRL_REPEAT_BIT]) begin
            state_r <= mseg_pkg::ST_ATK1;
          end
        end
        mseg_pkg::ST_REL1: begin
          state_r <= mseg_pkg::ST_REL2;
        end
        mseg_pkg::ST_REL2: begin
          state_r <= mseg_pkg::ST_IDLE;
        end
        default: begin
          state_r <= mseg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= 8'h00;
    end else if (voice_rst || !active || step_due || at_target) begin
      presc_r <= 8'h00;
    end else if (tick) begin
      presc_r <= presc_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      contour_level <= 8'h00;
    end else if (voice_rst) begin
      contour_level <= 8'h00;
    end else if (active && step_due && !at_target) begin
      // level moves one step toward the stage level per period, up or down
      if (contour_level < stage_level) begin
        contour_level <= contour_level + 8'h01;
      end else begin
        contour_level <= contour_level - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      contour_stage <= 3'h0;
    end else begin
      contour_stage <= state_r;
    end
  end

  // ----------------------------------------
  // cutoff routing
  // ----------------------------------------
  always_comb begin
    logic signed [17:0] prod;
    logic signed [17:0] sum;
    prod = $signed({{10{amount_r[7]}}, amount_r}) *
           $signed({10'h000, contour_level});
    sum  = $signed({10'h000, base_r}) + (prod >>> 7);
    if (ctrl_r[mseg_pkg::CTRL_ROUTE_BIT]) begin
      cutoff_nxt = clamp8(sum);
    end else begin
      cutoff_nxt = base_r;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cutoff_destination <= mseg_pkg::BASE_RST;
    end else begin
      cutoff_destination <= cutoff_nxt;
    end
  end

endmodule
